// file: rtl/i2csw_consts.vh
/*
  Constants for the four-channel bus switch.
  Assumes a 40 MHz system clock; the bus pins are sampled, not clocked on.
*/
// Overview of operation
// - Upstream clock/data pair connects to any combination of four downstream pairs.
// - Four active-low interrupt inputs, one per downstream channel.
// - Interrupt output is the AND of the four interrupt inputs.
// - Reset pin low returns serial engine to idle, deselects all channels.
// - Power-on reset likewise idles the serial engine and deselects channels.
// - Two address pins choose one of four target addresses.
`ifndef I2CSW_CONSTS_VH
`define I2CSW_CONSTS_VH
`define I2CSW_NCH        4
`define I2CSW_ADDR_BASE  5'h1C
`define I2CSW_CTRL_RST   4'h0
`define I2CSW_POR_CYC    4'hF
`define I2CSW_BIT_LAST   3'h7
`define I2CSW_BIT_FIRST  3'h0
`define I2CSW_ECHO_CYC   3'h5
`endif

// file: rtl/i2csw_sync.v
/*
  Three-stage input synchroniser with change qualification.
  Assumes an asynchronous input; output moves when stages two and three agree.
*/
`timescale 1ns/1ps
module i2csw_sync
(
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // pin side
  input  wire pinIn,
  // filtered level
  output reg  level
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end
    else
    begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule // i2csw_sync

// file: rtl/i2csw_switch.v
/*
  Four-channel bus switch: serial target with one control register,
  channel connect logic and interrupt combining.
  Assumes open-drain bus pins resolved outside; output enable high pulls low.
*/
`timescale 1ns/1ps
`include "i2csw_consts.vh"
module i2csw_switch
(
  // clock and reset
  input  wire                   clk,
  input  wire                   rst_n,
  // address select pins
  input  wire [1:0]             addrSel,
  // upstream bus
  input  wire                   upClkIn,
  output wire                   upClkOut,
  output wire                   upClkOe,
  input  wire                   upDataIn,
  output wire                   upDataOut,
  output wire                   upDataOe,
  // downstream buses
  input  wire [`I2CSW_NCH-1:0]  downstream_clock_line_in,
  output wire [`I2CSW_NCH-1:0]  downstream_clock_line_out,
  output wire [`I2CSW_NCH-1:0]  downstream_clock_line_oe,
  input  wire [`I2CSW_NCH-1:0]  downstream_data_line_in,
  output wire [`I2CSW_NCH-1:0]  downstream_data_line_out,
  output wire [`I2CSW_NCH-1:0]  downstream_data_line_oe,
  // interrupts
  input  wire [`I2CSW_NCH-1:0]  downstream_irq_in_n,
  output wire                   irqOut_n,
  // selection status
  output reg  [`I2CSW_NCH-1:0]  chanSel
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_ADDR = 5'b00010;
  localparam ST_AACK = 5'b00100;
  localparam ST_DATA = 5'b01000;
  localparam ST_DACK = 5'b10000;

  wire       sclS;
  wire       sdaS;
  wire [1:0] addrSelS;
  reg        clkUpOwn;
  reg        clkDnOwn;
  reg  [2:0] clkHold;
  reg        dataUpOwn;
  reg        dataDnOwn;
  reg  [2:0] dataHold;
  reg        addrFull;
  wire [`I2CSW_NCH-1:0] dnClkS;
  wire [`I2CSW_NCH-1:0] dnDataS;
  wire [`I2CSW_NCH-1:0] irqS;
  reg        sclD;
  reg        sdaD;
  reg  [4:0] state;
  reg  [2:0] bitCnt;
  reg  [7:0] shifter;
  reg        isRead;
  reg        ackDrive;
  reg        txDrive;
  reg  [3:0] porCnt;
  reg        porDone;

  i2csw_sync uSyncScl (.clk(clk), .rst_n(rst_n), .pinIn(upClkIn), .level(sclS));
  i2csw_sync uSyncSda (.clk(clk), .rst_n(rst_n), .pinIn(upDataIn), .level(sdaS));
  i2csw_sync uSyncA0  (.clk(clk), .rst_n(rst_n), .pinIn(addrSel[0]), .level(addrSelS[0]));
  i2csw_sync uSyncA1  (.clk(clk), .rst_n(rst_n), .pinIn(addrSel[1]), .level(addrSelS[1]));

  genvar g;
  generate
    for (g = 0; g < `I2CSW_NCH; g = g + 1)
    begin : gCh
      i2csw_sync uDc (.clk(clk), .rst_n(rst_n), .pinIn(downstream_clock_line_in[g]),
                      .level(dnClkS[g]));
      i2csw_sync uDd (.clk(clk), .rst_n(rst_n), .pinIn(downstream_data_line_in[g]),
                      .level(dnDataS[g]));
      i2csw_sync uIr (.clk(clk), .rst_n(rst_n), .pinIn(downstream_irq_in_n[g]),
                      .level(irqS[g]));
      // pass-gate model: a selected channel mirrors the upstream lows
      assign downstream_clock_line_out[g] = 1'b0;
      assign downstream_data_line_out[g]  = 1'b0;
      assign downstream_clock_line_oe[g]  = chanSel[g] & clkUpOwn;
      assign downstream_data_line_oe[g]   = chanSel[g] & dataUpOwn;
    end
  endgenerate

  assign irqOut_n = &irqS;

  wire sclRise = sclS & ~sclD;
  wire sclFall = ~sclS & sclD;
  wire startC  = sclS & sdaD & ~sdaS;
  wire stopC   = sclS & ~sdaD & sdaS;
  // downstream lows reach upstream only for selected channels
  wire dnClkLow  = |(chanSel & ~dnClkS);
  wire dnDataLow = |(chanSel & ~dnDataS);
  wire addrHit   = (shifter[7:1] == {`I2CSW_ADDR_BASE, addrSelS});

  assign upClkOut  = 1'b0;
  assign upDataOut = 1'b0;
  assign upClkOe   = clkDnOwn;
  assign upDataOe  = ackDrive | txDrive | dataDnOwn;

  // side that pulled low first owns the line; a hold-off after release hides
  // the echo still in the synchronisers, else the mirror latches itself low.
  // limitation: a target stretching while upstream owns the line is not seen
  always @(posedge clk)
  begin
    if (!rst_n || !porDone)
    begin
      clkUpOwn  <= 1'b0;
      clkDnOwn  <= 1'b0;
      clkHold   <= 3'h0;
      dataUpOwn <= 1'b0;
      dataDnOwn <= 1'b0;
      dataHold  <= 3'h0;
    end
    else
    begin
      if (clkHold != 3'h0)
        clkHold <= clkHold - 3'h1;
      if (clkUpOwn ? sclS : clkDnOwn & ~dnClkLow)
      begin
        clkUpOwn <= 1'b0;
        clkDnOwn <= 1'b0;
        clkHold  <= `I2CSW_ECHO_CYC;
      end
      else if (!clkUpOwn && !clkDnOwn && clkHold == 3'h0)
      begin
        clkUpOwn <= ~sclS;
        clkDnOwn <= sclS & dnClkLow;
      end
      if (dataHold != 3'h0)
        dataHold <= dataHold - 3'h1;
      if (dataUpOwn ? sdaS : dataDnOwn & ~dnDataLow)
      begin
        dataUpOwn <= 1'b0;
        dataDnOwn <= 1'b0;
        dataHold  <= `I2CSW_ECHO_CYC;
      end
      else if (!dataUpOwn && !dataDnOwn && dataHold == 3'h0)
      begin
        dataUpOwn <= ~sdaS;
        dataDnOwn <= sdaS & dnDataLow;
      end
    end
  end

  // internal power-on reset: held until counter expires
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      porCnt  <= `I2CSW_CTRL_RST;
      porDone <= 1'b0;
    end
    else if (!porDone)
    begin
      porCnt  <= porCnt + 4'h1;
      porDone <= (porCnt == `I2CSW_POR_CYC);
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n || !porDone)
    begin
      state    <= ST_IDLE;
      chanSel  <= `I2CSW_CTRL_RST;
      sclD     <= 1'b1;
      sdaD     <= 1'b1;
      bitCnt   <= `I2CSW_BIT_FIRST;
      shifter  <= 8'h00;
      isRead   <= 1'b0;
      ackDrive <= 1'b0;
      txDrive  <= 1'b0;
      addrFull <= 1'b0;
    end
    else
    begin
      sclD <= sclS;
      sdaD <= sdaS;
      if (startC)
      begin
        state    <= ST_ADDR;
        bitCnt   <= `I2CSW_BIT_FIRST;
        ackDrive <= 1'b0;
        txDrive  <= 1'b0;
        addrFull <= 1'b0;
      end
      else if (stopC)
      begin
        state    <= ST_IDLE;
        ackDrive <= 1'b0;
        txDrive  <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
            state <= ST_IDLE;
          ST_ADDR:
            if (sclRise)
            begin
              shifter <= {shifter[6:0], sdaS};
              bitCnt  <= bitCnt + 3'h1;
              if (bitCnt == `I2CSW_BIT_LAST)
                addrFull <= 1'b1;
            end
            // the fall right after start carries no address yet
            else if (sclFall && addrFull)
            begin
              addrFull <= 1'b0;
              if (addrHit)
              begin
                isRead   <= shifter[0];
                ackDrive <= 1'b1;
                state    <= ST_AACK;
              end
              else
                state <= ST_IDLE;
            end
          ST_AACK:
            if (sclFall)
            begin
              ackDrive <= 1'b0;
              state    <= ST_DATA;
              if (isRead)
              begin
                shifter <= {4'h0, chanSel};
                // upper nibble reads as zero: first bit drives low
                txDrive <= 1'b1;
              end
            end
          ST_DATA:
            if (isRead)
            begin
              if (sclFall)
              begin
                // next bit goes out with the shift, well before the rise
                shifter <= {shifter[6:0], 1'b0};
                txDrive <= ~shifter[6];
                bitCnt  <= bitCnt + 3'h1;
                if (bitCnt == `I2CSW_BIT_LAST)
                begin
                  txDrive <= 1'b0;
                  state   <= ST_DACK;
                end
              end
            end
            else if (sclRise)
            begin
              shifter <= {shifter[6:0], sdaS};
              bitCnt  <= bitCnt + 3'h1;
            end
            else if (sclFall && bitCnt == `I2CSW_BIT_FIRST)
            begin
              chanSel  <= shifter[`I2CSW_NCH-1:0];
              ackDrive <= 1'b1;
              state    <= ST_DACK;
            end
          ST_DACK:
            if (isRead)
            begin
              if (sclRise)
                state <= sdaS ? ST_IDLE : ST_AACK;
            end
            else if (sclFall)
            begin
              ackDrive <= 1'b0;
              state    <= ST_DATA;
            end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // i2csw_switch

// file: dv/i2csw_switch_properties.sv
/* Checker for the switch top.
   Assumes a synchronous active-low reset. */
`timescale 1ns/1ps
module i2csw_switch_properties
(
  // clock, reset
  input wire       clk,
  input wire       rst_n,
  // upstream
  input wire       upClkIn,
  input wire       upClkOe,
  input wire       upDataOe,
  // downstream, status
  input wire [3:0] downstream_clock_line_in,
  input wire [3:0] downstream_clock_line_oe,
  input wire [3:0] downstream_data_line_oe,
  input wire [3:0] downstream_irq_in_n,
  input wire       irqOut_n,
  input wire [3:0] chanSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_irq_idle: assert property ((&downstream_irq_in_n)[*8] |-> irqOut_n)
    else $error("irq out low");
  a_irq_any: assert property ((!(&downstream_irq_in_n))[*8] |-> !irqOut_n)
    else $error("irq out high");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> chanSel == 4'h0)
    else $error("select kept");
  a_por_idle: assert property ($rose(rst_n) |-> (chanSel == 4'h0 && !upDataOe)[*8])
    else $error("busy after reset");
  a_oe_selected: assert property ((downstream_data_line_oe & ~chanSel) == 4'h0)
    else $error("unselected drive");
  a_clk_follow: assert property ($stable(upClkIn)[*8] |->
    downstream_clock_line_oe == (upClkIn ? 4'h0 : chanSel)) else $error("clock not passed");
  a_no_stretch: assert property ((&downstream_clock_line_in)[*8] |-> !upClkOe)
    else $error("clock held");
  a_sel_update: assert property ($changed(chanSel) |-> !upClkIn)
    else $error("select moved");
  cover property ($changed(chanSel));
  cover property (upDataOe ##1 !upDataOe);
  cover property ($rose(rst_n));
endmodule // i2csw_switch_properties
bind i2csw_switch i2csw_switch_properties i_i2csw_switch_properties (.*);

// file: dv/i2csw_target.sv
/* Downstream targets: open-drain pairs with pull-ups.
   Assumes the bench commands every hold. */
`timescale 1ns/1ps
module i2csw_target
(
  // switch drive
  input  wire [3:0] downstream_clock_line_oe,
  input  wire [3:0] downstream_data_line_oe,
  // commanded holds
  input  wire [3:0] holdClk,
  input  wire [3:0] holdData,
  // resolved lines
  output wire [3:0] downstream_clock_line_in,
  output wire [3:0] downstream_data_line_in
);
  // pull-up wins unless a party pulls low
  assign downstream_clock_line_in = ~(downstream_clock_line_oe | holdClk);
  assign downstream_data_line_in  = ~(downstream_data_line_oe | holdData);
endmodule // i2csw_target

// file: dv/i2csw_switch_bench.sv
/* Bench: bit-banged controller, random traffic.
   Assumes the target model and bound checker. */
`timescale 1ns/1ps
`include "i2csw_consts.vh"
module i2csw_switch_bench;
  reg        clk = 1'h0, rst_n = 1'h0, scl = 1'h1, sda = 1'h1, ack, b;
  reg  [1:0] addrSel = 2'h0;
  reg  [3:0] downstream_irq_in_n = 4'hF, holdClk = 4'h0, holdData = 4'h0, sel = 4'h0;
  reg  [7:0] d, r = 8'h00;
  integer    seed = 94, failures = 0, num_checks = 0, cyc = 0, a, i;
  wire       upClkOe, upDataOe, irqOut_n;
  wire [3:0] chanSel, downstream_clock_line_oe, downstream_data_line_oe;
  wire [3:0] downstream_clock_line_in, downstream_data_line_in;
  wire       upClkIn = scl & ~upClkOe;
  wire       upDataIn = sda & ~upDataOe;
  i2csw_switch i_i2csw_switch (.*, .upClkOut(), .upDataOut(),
    .downstream_clock_line_out(), .downstream_data_line_out());
  i2csw_target i_i2csw_target (.*);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 20000) end_of_test(1);
  task t(input integer n); repeat (n) @(posedge clk); endtask
  task chk(input [7:0] e, input [7:0] g, input string what);
    num_checks++;
    if (e !== g)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // 8 cycles a bit: 200 ns link clock; low six, high two, so the
  // synchronised answer settles before the rise
  task bit_(input v, output rv);
    sda <= v;
    t(4);
    scl <= 1'h1;
    t(1);
    rv = upDataIn;
    t(1);
    scl <= 1'h0;
    t(2);
  endtask
  // data phase of a read releases the line; last bit is master nack
  task xfer(input [7:0] hdr, input [7:0] v);
    sda <= 1'h0;
    t(4);
    scl <= 1'h0;
    t(2);
    for (i = 7; i >= 0; i--) bit_(hdr[i], b);
    bit_(1'h1, ack);
    for (i = 7; i >= 0; i--) bit_(hdr[0] | v[i], r[i]);
    bit_(1'h1, b);
    sda <= 1'h0;
    t(2);
    scl <= 1'h1;
    t(2);
    sda <= 1'h1;
    t(4);
  endtask
  task end_of_test(input integer extra);
    failures = failures + extra;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    t(6);
    rst_n <= 1'h1;
    t(24);
    chk(8'h00, chanSel, "select");
    for (a = 0; a < 10; a++)
    begin
      downstream_irq_in_n <= a < 4 ? ~(4'h1 << a) : a == 4 ? 4'hF : 4'($random(seed));
      t(8);
      chk(8'(&downstream_irq_in_n), irqOut_n, "irq");
    end
    for (a = 0; a < 4; a++)
    begin
      addrSel <= a[1:0];
      d = a == 0 ? 8'h0F : a == 1 ? 8'hF0 : 8'($random(seed));
      t(4);
      xfer({`I2CSW_ADDR_BASE, ~a[1:0], 1'h0}, ~d);
      chk(8'h01, ack, "foreign ack");
      chk({4'h0, sel}, chanSel, "kept");
      xfer({`I2CSW_ADDR_BASE, a[1:0], 1'h0}, d);
      sel = d[3:0];
      chk(8'h00, {ack, b}, "acks");
      chk({4'h0, sel}, chanSel, "select");
      xfer({`I2CSW_ADDR_BASE, a[1:0], 1'h1}, 8'h00);
      chk({4'h0, d[3:0]}, r, "read");
    end
    xfer({`I2CSW_ADDR_BASE, 2'h3, 1'h0}, 8'h05);
    holdClk <= 4'h2;
    holdData <= 4'h2;
    t(8);
    chk(8'h00, {upClkOe, upDataOe}, "unselected");
    holdData <= 4'h3;
    scl <= 1'h0;
    t(8);
    chk(8'h15, {upDataOe, downstream_clock_line_oe}, "mirror");
    rst_n <= 1'h0;
    t(2);
    chk(8'h00, {chanSel, downstream_data_line_oe}, "reset");
    rst_n <= 1'h1;
    holdClk <= 4'h0;
    holdData <= 4'h0;
    scl <= 1'h1;
    t(24);
    xfer({`I2CSW_ADDR_BASE, 2'h3, 1'h0}, 8'h0A);
    chk(8'h0A, chanSel, "after reset");
    end_of_test(0);
  end
endmodule // i2csw_switch_bench
